/* File: core/qdec_top.sv */
// Three axis quadrature decoder core
`timescale 1ns/1ps
`include "qdec_consts.svh"
module qdec_top (
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire logic CLK_EN_I,
    input wire logic [`QDEC_GPIO_W-1:0] GPIO_I,
    input wire logic LOW_POWER_CLOCK_I,
    input wire logic [`QDEC_DIV_W-1:0] SAMPLE_CLOCK_DIVIDER_I,
    input wire qdec_pkg::qdec_axis_cfg_type X_CFG_I,
    input wire qdec_pkg::qdec_axis_cfg_type Y_CFG_I,
    input wire qdec_pkg::qdec_axis_cfg_type Z_CFG_I,
    input wire logic [`QDEC_EDGE_W-1:0] EDGE_IRQ_THRESHOLD_I,
    input wire logic IRQ_CLEAR_I,
    input wire logic EDGE_COUNT_CLEAR_I,
    output qdec_pkg::qdec_steps_type STEP_COUNT_O,
    output logic [`QDEC_EDGE_W-1:0] OVERALL_EDGE_COUNT_O,
    output logic DECODER_IRQ_FLAG_O,
    output logic MOVEMENT_WAKE_O
);
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Sampling strobe
    logic [`QDEC_DIV_W-1:0] div_cnt;
    logic [`QDEC_DIV_W-1:0] next_div_cnt;
    logic sample;
    logic [`QDEC_DIV_W-1:0] div_eff;

    always_comb begin
        // Clamp keeps the sample rate at or below the ceiling while LOW_POWER_CLOCK_I is low; low power samples every cycle
        div_eff = SAMPLE_CLOCK_DIVIDER_I;
        if (div_eff < `QDEC_DIV_W'(`QDEC_MIN_DIV)) begin
            div_eff = `QDEC_DIV_W'(`QDEC_MIN_DIV);
        end
        sample = 1'b0;
        next_div_cnt = div_cnt + 1'b1;
        if (LOW_POWER_CLOCK_I) begin
            sample = 1'b1;
            next_div_cnt = '0;
        end else if (div_cnt >= div_eff - `QDEC_DIV_ONE) begin
            sample = 1'b1;
            next_div_cnt = '0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else if (CLK_EN_I) begin
            div_cnt <= next_div_cnt;
        end
    end

    // Per axis filtering and decoding
    qdec_pkg::qdec_axis_cfg_type cfg [`QDEC_AXES];
    assign cfg[0] = X_CFG_I;
    assign cfg[1] = Y_CFG_I;
    assign cfg[2] = Z_CFG_I;

    logic [`QDEC_STEP_W-1:0] step [`QDEC_AXES];
    logic [`QDEC_STEP_W-1:0] next_step [`QDEC_AXES];
    logic [`QDEC_AXES-1:0] axis_edge;

    genvar g;
    generate
        for (g = 0; g < `QDEC_AXES; g++) begin : g_axis
            logic lvl_a;
            logic lvl_b;
            logic edg_a;
            logic edg_b;
            logic raw_a;
            logic raw_b;
            logic [`QDEC_STEP_W-1:0] count;
            logic [`QDEC_STEP_W-1:0] next_count;
            assign raw_a = GPIO_I[cfg[g].pin_a];
            assign raw_b = GPIO_I[cfg[g].pin_b];

            qdec_filter u_fa (
                .clk_i(CORE_CLK_I),
                .rst_n_i(rst_n),
                .ce_i(CLK_EN_I),
                .sample_i(sample),
                .raw_i(raw_a),
                .level_o(lvl_a),
                .edge_o(edg_a)
            );
            qdec_filter u_fb (
                .clk_i(CORE_CLK_I),
                .rst_n_i(rst_n),
                .ce_i(CLK_EN_I),
                .sample_i(sample),
                .raw_i(raw_b),
                .level_o(lvl_b),
                .edge_o(edg_b)
            );

            assign axis_edge[g] = cfg[g].enable && (edg_a || edg_b);

            // Counter lives in this scope, so each axis has a single driving process
            always_comb begin
                next_count = count;
                if (!cfg[g].enable) begin
                    next_count = `QDEC_STEP_RST;
                end else if (cfg[g].mode == qdec_pkg::QDEC_MODE_EDGE) begin
                    if (edg_a || edg_b) begin
                        next_count = count + 1'b1;
                    end
                end else if (edg_a != edg_b) begin
                    // A edge: A now differs from B means A leads
                    if ((edg_a && ((!lvl_a) != lvl_b)) || (edg_b && ((!lvl_b) == lvl_a))) begin
                        next_count = count + 1'b1;
                    end else begin
                        next_count = count - 1'b1;
                    end
                end
            end

            always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
                if (!rst_n) begin
                    count <= `QDEC_STEP_RST;
                end else if (CLK_EN_I) begin
                    count <= next_count;
                end
            end

            assign step[g] = count;
            assign next_step[g] = next_count;
        end
    endgenerate

    // Overall edge counter, interrupt and wake
    logic [`QDEC_EDGE_W-1:0] edge_cnt;
    logic [`QDEC_EDGE_W-1:0] next_edge_cnt;
    logic irq;
    logic next_irq;
    logic any_edge;
    logic wake;
    logic next_wake;

    always_comb begin
        any_edge = |axis_edge;
        next_edge_cnt = edge_cnt;
        if (any_edge) begin
            next_edge_cnt = edge_cnt + 1'b1;
        end else if (EDGE_COUNT_CLEAR_I) begin
            next_edge_cnt = `QDEC_EDGE_RST;
        end
        if (EDGE_COUNT_CLEAR_I && any_edge) begin
            next_edge_cnt = `QDEC_EDGE_W'(1);
        end
        next_irq = irq;
        if (IRQ_CLEAR_I) begin
            next_irq = 1'b0;
        end
        if (any_edge && next_edge_cnt == EDGE_IRQ_THRESHOLD_I) begin
            next_irq = 1'b1;
        end
        next_wake = any_edge;
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt <= `QDEC_EDGE_RST;
            irq <= 1'b0;
            wake <= 1'b0;
        end else if (CLK_EN_I) begin
            edge_cnt <= next_edge_cnt;
            irq <= next_irq;
            wake <= next_wake;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            STEP_COUNT_O <= '0;
            OVERALL_EDGE_COUNT_O <= `QDEC_EDGE_RST;
            DECODER_IRQ_FLAG_O <= 1'b0;
            MOVEMENT_WAKE_O <= 1'b0;
        end else if (CLK_EN_I) begin
            STEP_COUNT_O <= {next_step[0], next_step[1], next_step[2]};
            OVERALL_EDGE_COUNT_O <= next_edge_cnt;
            DECODER_IRQ_FLAG_O <= next_irq;
            MOVEMENT_WAKE_O <= next_wake;
        end
    end

    AST_IRQ_STICKY: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && irq && !IRQ_CLEAR_I) |=> irq)
        else $error("irq dropped without clear");
    AST_IRQ_CLEAR: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && IRQ_CLEAR_I && !any_edge) |=> !irq)
        else $error("irq not cleared");
    AST_EDGE_ONE: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && any_edge && !EDGE_COUNT_CLEAR_I) |=> edge_cnt == $past(edge_cnt) + 8'h01)
        else $error("edge count step wrong");
    AST_EDGE_CLR: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && EDGE_COUNT_CLEAR_I && !any_edge) |=> edge_cnt == `QDEC_EDGE_RST)
        else $error("edge count not cleared");
    AST_AXIS_DIS: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && !X_CFG_I.enable) |=> step[0] == `QDEC_STEP_RST)
        else $error("disabled axis not zero");
    AST_FROZEN: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        !CLK_EN_I |=> $stable(edge_cnt) && $stable(irq))
        else $error("state moved while disabled");
    AST_LP_SAMPLE: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        LOW_POWER_CLOCK_I |-> sample)
        else $error("divider not bypassed");
    AST_RATE_CAP: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && !LOW_POWER_CLOCK_I && !$past(LOW_POWER_CLOCK_I) && sample) |=> !sample)
        else $error("sample strobes back to back with divider on");
    AST_X_STEP: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && X_CFG_I.enable && $past(X_CFG_I.enable) && $past(CLK_EN_I))
            |-> (step[0] - $past(step[0]) == 16'h0000) || (step[0] - $past(step[0]) == 16'h0001)
            || (step[0] - $past(step[0]) == 16'hffff))
        else $error("axis moved by more than one");
    AST_IRQ_SET: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CLK_EN_I && any_edge && next_edge_cnt == EDGE_IRQ_THRESHOLD_I) |=> irq)
        else $error("irq missed threshold");
endmodule : qdec_top

/* File: core/qdec_consts.svh */
// Constants for the three axis quadrature decoder
`ifndef QDEC_CONSTS_SVH
`define QDEC_CONSTS_SVH
`define QDEC_GPIO_W 12
`define QDEC_SEL_W 4
`define QDEC_STEP_W 16
`define QDEC_EDGE_W 8
`define QDEC_DIV_W 10
`define QDEC_AXES 3
`define QDEC_FILT_LEN 3
`define QDEC_FILT_CNT_W 2
`define QDEC_SYS_MHZ 200
`define QDEC_MAX_SAMPLE_MHZ 16
`define QDEC_MIN_DIV ((`QDEC_SYS_MHZ + `QDEC_MAX_SAMPLE_MHZ - 1) / `QDEC_MAX_SAMPLE_MHZ)
`define QDEC_STEP_RST 16'h0000
`define QDEC_EDGE_RST 8'h00
`define QDEC_DIV_ONE 10'h001
`endif

/* File: core/qdec_pkg.sv */
// Types for the three axis quadrature decoder
`include "qdec_consts.svh"
package qdec_pkg;
    typedef enum logic {
        QDEC_MODE_QUAD,
        QDEC_MODE_EDGE
    } qdec_mode_type;

    typedef struct packed {
        logic enable;
        qdec_mode_type mode;
        logic [`QDEC_SEL_W-1:0] pin_a;
        logic [`QDEC_SEL_W-1:0] pin_b;
    } qdec_axis_cfg_type;

    typedef struct packed {
        logic signed [`QDEC_STEP_W-1:0] x;
        logic signed [`QDEC_STEP_W-1:0] y;
        logic signed [`QDEC_STEP_W-1:0] z;
    } qdec_steps_type;
endpackage : qdec_pkg

/* File: core/qdec_filter.sv */
// Spike filter and edge detector for one channel
`timescale 1ns/1ps
`include "qdec_consts.svh"
module qdec_filter (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sample_i,
    input wire logic raw_i,
    output logic level_o,
    output logic edge_o
);
    logic [`QDEC_FILT_CNT_W-1:0] cnt;
    logic [`QDEC_FILT_CNT_W-1:0] next_cnt;
    logic level;
    logic next_level;

    always_comb begin
        next_cnt = cnt;
        next_level = level;
        if (sample_i) begin
            // Level moves only after three equal samples against it
            if (raw_i == level) begin
                next_cnt = '0;
            end else if (cnt == `QDEC_FILT_CNT_W'(`QDEC_FILT_LEN - 1)) begin
                next_cnt = '0;
                next_level = raw_i;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            level <= 1'b0;
        end else if (ce_i) begin
            cnt <= next_cnt;
            level <= next_level;
        end
    end

    assign level_o = level;
    assign edge_o = sample_i && (next_level != level);
endmodule : qdec_filter

/* File: sim/qdec_encoder.sv */
// Behavioural quadrature encoder standing in for the motion device
`timescale 1ns/1ps
module qdec_encoder (
    input wire logic clk_i,
    output logic [11:0] pins_o
);
    initial pins_o = 12'h000;

    // Toggle the masked pins together, then hold for a number of cycles
    task automatic flip(input logic [11:0] mask, input int hold);
        @(negedge clk_i);
        pins_o = pins_o ^ mask;
        repeat (hold - 1) @(negedge clk_i);
    endtask : flip

    // One quarter period per step, A leading when moving forward
    task automatic move(input int a, input int b, input bit fwd, input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            if (fwd == (pins_o[a] == pins_o[b])) flip(12'h001 << a, hold);
            else flip(12'h001 << b, hold);
        end
    endtask : move
endmodule : qdec_encoder

/* File: sim/three_axis_quadrature_decoder_test.sv */
// Self-checking bench for the three axis quadrature decoder
`timescale 1ns/1ps
module three_axis_quadrature_decoder_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic low_power = 1'b1;
    logic [9:0] div = 10'h00d;
    logic [7:0] thr = 8'hff;
    logic irq_clr = 1'b0;
    logic cnt_clr = 1'b0;
    logic [11:0] pins;
    qdec_pkg::qdec_axis_cfg_type x_cfg = '0;
    qdec_pkg::qdec_axis_cfg_type y_cfg = '0;
    qdec_pkg::qdec_axis_cfg_type z_cfg = '0;
    qdec_pkg::qdec_steps_type steps;
    logic [7:0] edges;
    logic irq;
    logic wake;
    logic [7:0] exp_edges = 8'h00;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_wake = 0;
    int exp_ev = 0;

    always #2.5 clk = ~clk;

    qdec_encoder enc (.clk_i(clk), .pins_o(pins));

    qdec_top dut (
        .CORE_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(clk_en), .GPIO_I(pins),
        .LOW_POWER_CLOCK_I(low_power), .SAMPLE_CLOCK_DIVIDER_I(div),
        .X_CFG_I(x_cfg), .Y_CFG_I(y_cfg), .Z_CFG_I(z_cfg),
        .EDGE_IRQ_THRESHOLD_I(thr), .IRQ_CLEAR_I(irq_clr), .EDGE_COUNT_CLEAR_I(cnt_clr),
        .STEP_COUNT_O(steps), .OVERALL_EDGE_COUNT_O(edges),
        .DECODER_IRQ_FLAG_O(irq), .MOVEMENT_WAKE_O(wake)
    );

    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Wake is counted mid-cycle, where the registered pulse has settled
    always @(negedge clk) begin
        if (wake === 1'b1) n_wake <= n_wake + 1;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_edges;
        chk("edge count", {8'h00, exp_edges}, {8'h00, edges});
    endtask : chk_edges

    task automatic add(input int n);
        exp_edges = exp_edges + 8'(n);
        exp_ev += n;
    endtask : add

    task automatic t_quad;
        x_cfg = '{1'b1, qdec_pkg::QDEC_MODE_QUAD, 4'h0, 4'h1};
        enc.move(0, 1, 1'b1, 12, 4);
        wait_n(5);
        chk("x forward", 16'h000c, steps.x);
        enc.move(0, 1, 1'b0, 8, 4);
        wait_n(5);
        chk("x backward", 16'h0004, steps.x);
        add(20);
        chk_edges;
        $display("test quad done");
    endtask : t_quad

    task automatic t_edge;
        y_cfg = '{1'b1, qdec_pkg::QDEC_MODE_EDGE, 4'h2, 4'h3};
        repeat (3) enc.flip(12'h00c, 4);
        wait_n(5);
        chk("y edges", 16'h0003, steps.y);
        add(3);
        chk_edges;
        $display("test edge done");
    endtask : t_edge

    task automatic t_spike;
        enc.flip(12'h001, 2);
        enc.flip(12'h001, 6);
        chk_edges;
        enc.flip(12'h001, 3);
        enc.flip(12'h001, 6);
        add(2);
        chk_edges;
        chk("x after pulse", 16'h0004, steps.x);
        $display("test spike done");
    endtask : t_spike

    task automatic t_div;
        low_power = 1'b0;
        div = 10'h001;
        enc.flip(12'h001, 20);
        enc.flip(12'h001, 80);
        chk_edges;
        enc.flip(12'h001, 60);
        enc.flip(12'h001, 80);
        add(2);
        chk_edges;
        low_power = 1'b1;
        $display("test divider done");
    endtask : t_div

    task automatic t_clken;
        clk_en = 1'b0;
        enc.move(0, 1, 1'b1, 4, 4);
        clk_en = 1'b1;
        wait_n(5);
        chk("x frozen", 16'h0004, steps.x);
        chk_edges;
        $display("test enable done");
    endtask : t_clken

    task automatic t_irq;
        cnt_clr = 1'b1;
        wait_n(1);
        cnt_clr = 1'b0;
        wait_n(2);
        exp_edges = 8'h00;
        chk_edges;
        thr = 8'h03;
        enc.move(0, 1, 1'b1, 2, 4);
        wait_n(5);
        chk("irq below", 16'h0000, {15'h0000, irq});
        enc.move(0, 1, 1'b1, 1, 4);
        wait_n(5);
        chk("irq at threshold", 16'h0001, {15'h0000, irq});
        enc.move(0, 1, 1'b1, 1, 4);
        wait_n(5);
        add(4);
        chk_edges;
        chk("irq sticky", 16'h0001, {15'h0000, irq});
        irq_clr = 1'b1;
        wait_n(1);
        irq_clr = 1'b0;
        wait_n(2);
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        chk("x after irq", 16'h0008, steps.x);
        $display("test irq done");
    endtask : t_irq

    task automatic t_dis;
        x_cfg.enable = 1'b0;
        wait_n(3);
        chk("x disabled", 16'h0000, steps.x);
        chk("z disabled", 16'h0000, steps.z);
        chk("wake pulses", 16'(exp_ev), 16'(n_wake));
        $display("test disable done");
    endtask : t_dis

    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        wait_n(4);
        t_quad;
        t_edge;
        t_spike;
        t_div;
        t_clken;
        t_irq;
        t_dis;
        final_report;
    end
endmodule : three_axis_quadrature_decoder_test
